// ==== logic/asio_port.sv ====
// Purpose: eight-pin port shared with analog inputs and timer disable inputs
// Assumes: pins and the trigger pin are asynchronous; converter and timers on clk_i
// Notes: registers on classic wishbone, one cycle to ack
// Summary of operation
// - as general io, direction bit 1 drives the pin, 0 makes it input.
// - software-written output values for eight pins are held in a latch.
// - latch read returns latched value where direction bit is 1.
// - latch read returns live pin level where direction bit is 0.
// - pins selected as analog inputs read as 0.
// - function bit 7 set makes pin 7 analog 15 or timer disable 1.
// - function bit 6 set makes pin 6 analog 14 or timer disable 0.
// - function bit 5 set makes pin 5 analog or second timer disable input.
// - function register bit 4 is reserved and always reads 1.
// - bits 3:2 pick start source: pin, timer 0, timer 1, reserved.
// - bit 1 picks trigger edge: 0 falling, 1 rising.
// - bit 0 makes neighbour pin 0 the external conversion trigger.
// - pin 7 analog for channel 15 in any scan; else function, else direction.
// - pin 6 analog for channel 14, or scan up to 15; else function, direction.
`timescale 1ns/1ps
module asio_port (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  pin_in_i,
	output logic      [7:0]  pin_out_o,
	output logic      [7:0]  pin_oe_n_o,
	input  wire logic [3:0]  channel_sel_i,
	input  wire logic        scan_mode_i,
	output logic      [7:0]  analog_sel_o,
	output logic             timer_disable_input_1_o,
	output logic             timer_disable_input_0_o,
	output logic             second_timer_disable_input_o,
	input  wire logic        neighbour_port_pin0_i,
	output logic             trigger_pin_enable_o,
	input  wire logic        timer0_start_i,
	input  wire logic        timer1_start_i,
	output logic             conversion_start_o
);

	logic [7:0]  pin_direction_ff;
	logic [7:0]  pin_output_latch_ff;
	logic [7:0]  pin_function_select_ff;
	logic [7:0]  pin_meta_ff;
	logic [7:0]  pin_sync_ff;
	logic        trig_meta_ff;
	logic        trig_sync_ff;
	logic        trig_prev_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  pin_out_ff;
	logic [7:0]  oe_n_ff;
	logic [7:0]  analog_ff;
	logic        tdi1_ff;
	logic        tdi0_ff;
	logic        tdi2_ff;
	logic        trigen_ff;
	logic        start_ff;

	logic        bus_req;
	logic        wr_en;
	logic        wr_dir;
	logic        wr_latch;
	logic        wr_fsel;
	logic [7:0]  analog;
	logic [7:0]  timer_sel;
	logic [7:0]  gpio_drive;
	logic [7:0]  latch_view;
	logic [7:0]  nxt_rdata;
	logic        nxt_start;
	logic        ext_edge;
	asio_pkg::asio_src_e src;

	asio_dec_if dec_bus ();

	assign dec_bus.channel_sel = channel_sel_i;
	assign dec_bus.scan_mode   = scan_mode_i;
	assign analog              = dec_bus.analog;

	asio_decode u_decode (
		.dec (dec_bus)
	);

	// bus request decode
	// ack_ff low is part of the take, so a held request is answered every other cycle
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr_en   = bus_req && wb_we_i && wb_sel_i[0];

	// address match for one register word
	function automatic logic asio_hit(input logic [3:0] adr, input logic [3:0] ofs);
		return adr == ofs;
	endfunction : asio_hit

	// per-register write strobes
	always_comb begin
		wr_dir   = wr_en && asio_hit(wb_adr_i, asio_pkg::ASIO_OFS_DIR);
		wr_latch = wr_en && asio_hit(wb_adr_i, asio_pkg::ASIO_OFS_LATCH);
		wr_fsel  = wr_en && asio_hit(wb_adr_i, asio_pkg::ASIO_OFS_FSEL);
	end

	// pin input synchroniser
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_meta_ff <= 8'h00;
			pin_sync_ff <= 8'h00;
		end else if (ce_i) begin
			pin_meta_ff <= pin_in_i;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// trigger pin synchroniser and edge history
	// history resets low; trigger enable is low then too, so no false start
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			trig_meta_ff <= 1'b0;
			trig_sync_ff <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else if (ce_i) begin
			trig_meta_ff <= neighbour_port_pin0_i;
			trig_sync_ff <= trig_meta_ff;
			trig_prev_ff <= trig_sync_ff;
		end
	end

	// direction register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_direction_ff <= asio_pkg::ASIO_RST_DIR;
		end else if (ce_i && wr_dir) begin
			pin_direction_ff <= wb_dat_i[7:0];
		end
	end

	// output data latch
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_output_latch_ff <= asio_pkg::ASIO_RST_LATCH;
		end else if (ce_i && wr_latch) begin
			pin_output_latch_ff <= wb_dat_i[7:0];
		end
	end

	// function select register, reserved bit held at 1
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_function_select_ff <= asio_pkg::ASIO_RST_FSEL;
		end else if (ce_i && wr_fsel) begin
			pin_function_select_ff <= (wb_dat_i[7:0] & asio_pkg::ASIO_FSEL_WMASK)
			                          | asio_pkg::ASIO_FSEL_FIXED1;
		end
	end

	// timer input selection on the upper pins
	always_comb begin
		timer_sel = 8'h00;
		timer_sel[asio_pkg::ASIO_BIT_PIN7] = pin_function_select_ff[asio_pkg::ASIO_BIT_PIN7];
		timer_sel[asio_pkg::ASIO_BIT_PIN6] = pin_function_select_ff[asio_pkg::ASIO_BIT_PIN6];
		timer_sel[asio_pkg::ASIO_BIT_PIN5] = pin_function_select_ff[asio_pkg::ASIO_BIT_PIN5];
	end

	// analog first, then timer input, then direction
	always_comb begin
		gpio_drive = 8'h00;
		for (int i = 0; i < asio_pkg::ASIO_PINS; i++) begin
			if (analog[i] || timer_sel[i]) begin
				gpio_drive[i] = 1'b0;
			end else begin
				gpio_drive[i] = pin_direction_ff[i];
			end
		end
	end

	// data latch read view
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_view
			assign latch_view[g] = analog[g] ? 1'b0 :
			                       pin_direction_ff[g] ? pin_output_latch_ff[g]
			                                           : pin_sync_ff[g];
		end
	endgenerate

	// read mux, direction reads as zero
	always_comb begin
		nxt_rdata = 8'h00;
		case (wb_adr_i)
			asio_pkg::ASIO_OFS_DIR: begin
				nxt_rdata = 8'h00;
			end
			asio_pkg::ASIO_OFS_LATCH: begin
				nxt_rdata = latch_view;
			end
			asio_pkg::ASIO_OFS_FSEL: begin
				nxt_rdata = pin_function_select_ff | asio_pkg::ASIO_FSEL_FIXED1;
			end
			default: begin
				nxt_rdata = 8'h00;
			end
		endcase
	end

	// wishbone answer, read data held until the next read
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end else if (ce_i) begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_i) begin
				rdata_ff <= {24'h000000, nxt_rdata};
			end
		end
	end

	// pin drivers
	// outputs lag the registers by one edge
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_out_ff <= asio_pkg::ASIO_RST_LATCH;
			oe_n_ff    <= 8'hff;
			analog_ff  <= 8'h00;
		end else if (ce_i) begin
			pin_out_ff <= pin_output_latch_ff;
			oe_n_ff    <= ~gpio_drive;
			analog_ff  <= analog;
		end
	end

	// timer disable level: synced pin when selected and not analog, else idle
	function automatic logic asio_tdi(input logic sel, input logic an, input logic lvl);
		return (sel && !an) ? lvl : asio_pkg::ASIO_TDI_IDLE;
	endfunction : asio_tdi

	// timer disable inputs, idle when not selected or pin is analog
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			tdi1_ff <= asio_pkg::ASIO_TDI_IDLE;
			tdi0_ff <= asio_pkg::ASIO_TDI_IDLE;
			tdi2_ff <= asio_pkg::ASIO_TDI_IDLE;
		end else if (ce_i) begin
			tdi1_ff <= asio_tdi(timer_sel[7], analog[7], pin_sync_ff[7]);
			tdi0_ff <= asio_tdi(timer_sel[6], analog[6], pin_sync_ff[6]);
			tdi2_ff <= asio_tdi(timer_sel[5], analog[5], pin_sync_ff[5]);
		end
	end

	// external trigger edge
	assign ext_edge = (pin_function_select_ff[asio_pkg::ASIO_BIT_EDGE] == asio_pkg::ASIO_EDGE_FALL)
	                  ? (trig_prev_ff && !trig_sync_ff)
	                  : (!trig_prev_ff && trig_sync_ff);

	// start source field
	assign src = asio_pkg::asio_src_e'(pin_function_select_ff[asio_pkg::ASIO_BIT_SRC_HI:
	                                                          asio_pkg::ASIO_BIT_SRC_LO]);

	// start source select
	// reserved source never starts a conversion
	always_comb begin
		nxt_start = 1'b0;
		case (src)
			asio_pkg::ASIO_SRC_PIN: begin
				nxt_start = ext_edge && pin_function_select_ff[asio_pkg::ASIO_BIT_TRIGEN];
			end
			asio_pkg::ASIO_SRC_TIMER0: begin
				nxt_start = timer0_start_i;
			end
			asio_pkg::ASIO_SRC_TIMER1: begin
				nxt_start = timer1_start_i;
			end
			default: begin
				nxt_start = 1'b0;
			end
		endcase
	end

	// conversion start and trigger pin function
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			start_ff  <= 1'b0;
			trigen_ff <= 1'b0;
		end else if (ce_i) begin
			start_ff  <= nxt_start;
			trigen_ff <= pin_function_select_ff[asio_pkg::ASIO_BIT_TRIGEN];
		end
	end

	assign wb_dat_o                     = rdata_ff;
	assign wb_ack_o                     = ack_ff;
	assign pin_out_o                    = pin_out_ff;
	assign pin_oe_n_o                   = oe_n_ff;
	assign analog_sel_o                 = analog_ff;
	assign timer_disable_input_1_o      = tdi1_ff;
	assign timer_disable_input_0_o      = tdi0_ff;
	assign second_timer_disable_input_o = tdi2_ff;
	assign trigger_pin_enable_o         = trigen_ff;
	assign conversion_start_o           = start_ff;

endmodule : asio_port

// ==== logic/asio_pkg.sv ====
// Purpose: constants shared by the shared analog/io port block
// Assumes: 32-bit classic wishbone, registers in low byte of each word
// Notes: one word per register, byte addresses below
package asio_pkg;

	localparam int          ASIO_PINS        = 8;
	localparam int          ASIO_ADR_W       = 4;

	localparam logic [3:0]  ASIO_OFS_DIR     = 4'h0;
	localparam logic [3:0]  ASIO_OFS_LATCH   = 4'h4;
	localparam logic [3:0]  ASIO_OFS_FSEL    = 4'h8;

	localparam logic [7:0]  ASIO_RST_DIR     = 8'h00;
	localparam logic [7:0]  ASIO_RST_LATCH   = 8'h08;
	localparam logic [7:0]  ASIO_RST_FSEL    = 8'h10;
	localparam logic [7:0]  ASIO_FSEL_WMASK  = 8'hef;
	localparam logic [7:0]  ASIO_FSEL_FIXED1 = 8'h10;

	localparam int          ASIO_BIT_PIN7    = 7;
	localparam int          ASIO_BIT_PIN6    = 6;
	localparam int          ASIO_BIT_PIN5    = 5;
	localparam int          ASIO_BIT_RSVD    = 4;
	localparam int          ASIO_BIT_SRC_HI  = 3;
	localparam int          ASIO_BIT_SRC_LO  = 2;
	localparam int          ASIO_BIT_EDGE    = 1;
	localparam int          ASIO_BIT_TRIGEN  = 0;

	localparam logic        ASIO_TDI_IDLE    = 1'b1;
	localparam logic        ASIO_EDGE_FALL   = 1'b0;

	typedef enum logic [1:0] {
		ASIO_SRC_PIN    = 2'b00,
		ASIO_SRC_TIMER0 = 2'b01,
		ASIO_SRC_TIMER1 = 2'b10,
		ASIO_SRC_RSVD   = 2'b11
	} asio_src_e;

endpackage : asio_pkg

// ==== logic/asio_dec_if.sv ====
// Purpose: carries converter channel settings to the analog decoder
// Assumes: converter settings are on the block clock
// Notes: analog holds one flag per port pin
`timescale 1ns/1ps
interface asio_dec_if;
	logic [3:0] channel_sel;
	logic       scan_mode;
	logic [7:0] analog;

	modport src (output channel_sel, output scan_mode, input analog);
	modport dec (input channel_sel, input scan_mode, output analog);
endinterface : asio_dec_if

// ==== logic/asio_decode.sv ====
// Purpose: decodes which port pins the converter is using as analog inputs
// Assumes: channel_sel[3] picks the upper bank of eight channels
// Notes: scan covers a group of four up to the selected channel
`timescale 1ns/1ps
module asio_decode (
	asio_dec_if.dec dec
);

	function automatic logic asio_is_analog(input logic [3:0] ch, input logic scan,
	                                        input logic [2:0] pin);
		logic single;
		logic grouped;
		single  = (ch[2:0] == pin);
		grouped = scan && (ch[2] == pin[2]) && (ch[1:0] >= pin[1:0]);
		return ch[3] && (single || grouped);
	endfunction : asio_is_analog

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			// analog flag per pin
			assign dec.analog[g] = asio_is_analog(dec.channel_sel, dec.scan_mode, 3'(g));
		end
	endgenerate

endmodule : asio_decode

// ==== test/asio_checker.sv ====
// Purpose: bus and analog decode properties of the shared port
// Assumes: ce_i held high by the bench
// Notes: bound from the testbench file
`timescale 1ns/1ps
module asio_checker (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [3:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [3:0]  channel_sel_i,
	input wire logic        scan_mode_i,
	input wire logic [7:0]  analog_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic rq;
	assign rq = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	property p_take; rq |=> wb_ack_o; endproperty
	a_take: assert property (p_take) else $error("no ack");
	property p_once; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
	a_once: assert property (p_once) else $error("ack long");
	property p_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("stray ack");
	property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data");
	property p_rsvd;
		rq && !wb_we_i && wb_adr_i == asio_pkg::ASIO_OFS_FSEL |=> wb_dat_o[4];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("bit4 not 1");
	property p_dir;
		rq && !wb_we_i && wb_adr_i == asio_pkg::ASIO_OFS_DIR |=> wb_dat_o[7:0] == 8'h00;
	endproperty
	a_dir: assert property (p_dir) else $error("dir readable");
	property p_analog_channel_15; ce_i && channel_sel_i == 4'hf |=> analog_sel_o[7]; endproperty
	a_analog_channel_15: assert property (p_analog_channel_15) else $error("pin7 analog");
	property p_analog_channel_14;
		ce_i && channel_sel_i[3:1] == 3'h7
		|=> analog_sel_o[6] == (!$past(channel_sel_i[0]) || $past(scan_mode_i));
	endproperty
	a_analog_channel_14: assert property (p_analog_channel_14) else $error("pin6 analog");
	property p_bank; ce_i && !channel_sel_i[3] |=> analog_sel_o == 8'h00; endproperty
	a_bank: assert property (p_bank) else $error("low bank");
	c_rd: cover property (rq && !wb_we_i);
	c_wr: cover property (rq && wb_we_i);
	c_scan: cover property (scan_mode_i && channel_sel_i == 4'hf);
endmodule : asio_checker

// ==== test/asio_board.sv ====
// Purpose: board levels on the shared port pins
// Assumes: each pin has a board source
// Notes: device level wins while it drives
`timescale 1ns/1ps
module asio_board (
	input  wire logic [7:0] pin_out_i,
	input  wire logic [7:0] pin_oe_n_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_o
);
	assign pin_o = (pin_oe_n_i & ext_i) | (~pin_oe_n_i & pin_out_i);
endmodule : asio_board

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the shared port
// Assumes: ce_i and sel held high
// Notes: expected values from the register rules
`timescale 1ns/1ps
module testbench;
	logic clk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, scan = 0, nb = 1, t0 = 0, t1 = 0;
	logic [3:0] adr = 4'h0, ch = 4'h0;
	logic [31:0] dat = 32'h0, dat_o;
	logic [7:0] ext = 8'h5a, pin_in, pin_out, oe_n, an;
	logic ack, td1, td0, td2, tpe, cs;
	int n_checks = 0, n_mismatch = 0, n_cyc = 0, n_start = 0;
	always #5 clk_i = ~clk_i;
	asio_port dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .pin_in_i(pin_in), .pin_out_o(pin_out),
		.pin_oe_n_o(oe_n), .channel_sel_i(ch), .scan_mode_i(scan), .analog_sel_o(an),
		.timer_disable_input_1_o(td1), .timer_disable_input_0_o(td0),
		.second_timer_disable_input_o(td2), .neighbour_port_pin0_i(nb),
		.trigger_pin_enable_o(tpe), .timer0_start_i(t0), .timer1_start_i(t1),
		.conversion_start_o(cs));
	asio_board board (.pin_out_i(pin_out), .pin_oe_n_i(oe_n), .ext_i(ext), .pin_o(pin_in));
	always @(posedge clk_i) begin
		n_cyc++;
		if (cs === 1'b1) n_start++;
		if (n_cyc == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o[7:0];
		{cyc, stb, we} <= 3'b000;
	endtask : wb
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, e, q);
	endtask : rc
	task automatic t_reset;
		chk("oe_n", 8'hff, oe_n);
		chk("pin_out", 8'h08, pin_out);
		rc("dir", 4'h0, 8'h00);
		rc("fsel", 4'h8, 8'h10);
		rc("unmapped", 4'hc, 8'h00);
		rc("pins", 4'h4, 8'h5a);
		$display("test reset done");
	endtask : t_reset
	task automatic t_io;
		wr(4'h4, 8'ha5);
		wr(4'h0, 8'h0f);
		ext <= 8'h3c;
		tick(4);
		chk("oe_n", 8'hf0, oe_n);
		chk("pin_out", 8'ha5, pin_out);
		rc("latch", 4'h4, 8'h35);
		$display("test io done");
	endtask : t_io
	task automatic t_analog;
		logic [3:0] c_t[4] = '{4'hf, 4'hf, 4'he, 4'hd};
		logic s_t[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
		logic [7:0] m_t[4] = '{8'h80, 8'hf0, 8'h40, 8'h20};
		ext <= 8'hff;
		for (int i = 0; i < 4; i++) begin
			{ch, scan} <= {c_t[i], s_t[i]};
			tick(4);
			chk("analog", m_t[i], an);
			rc("latch", 4'h4, 8'hf5 & ~m_t[i]);
		end
		{ch, scan} <= 5'h00;
		$display("test analog done");
	endtask : t_analog
	task automatic t_fsel;
		wr(4'h8, 8'he0);
		wr(4'h0, 8'hff);
		ext <= 8'h00;
		tick(5);
		chk("oe_n", 8'he0, oe_n);
		chk("disable", 8'h00, {5'h00, td1, td0, td2});
		ch <= 4'hf;
		tick(4);
		chk("disable", 8'h04, {5'h00, td1, td0, td2});
		ch <= 4'h0;
		ext <= 8'hff;
		tick(5);
		chk("disable", 8'h07, {5'h00, td1, td0, td2});
		rc("fsel", 4'h8, 8'hf0);
		$display("test fsel done");
	endtask : t_fsel
	task automatic edge_cnt(input logic [7:0] f, input logic v, input logic [7:0] e);
		int s0;
		wr(4'h8, f);
		tick(2);
		s0 = n_start;
		nb <= v;
		tick(8);
		chk("start", e, 8'(n_start - s0));
	endtask : edge_cnt
	task automatic t_start;
		int s0;
		for (int s = 0; s < 4; s++) begin
			wr(4'h8, 8'(s << 2));
			s0 = n_start;
			@(posedge clk_i) t0 <= 1'b1;
			@(posedge clk_i) t0 <= 1'b0;
			tick(3);
			chk("timer0", (s == 1) ? 8'h01 : 8'h00, 8'(n_start - s0));
			s0 = n_start;
			@(posedge clk_i) t1 <= 1'b1;
			@(posedge clk_i) t1 <= 1'b0;
			tick(3);
			chk("timer1", (s == 2) ? 8'h01 : 8'h00, 8'(n_start - s0));
		end
		edge_cnt(8'h01, 1'b0, 8'h01);
		chk("trig_en", 8'h01, {7'h00, tpe});
		edge_cnt(8'h01, 1'b1, 8'h00);
		edge_cnt(8'h03, 1'b0, 8'h00);
		edge_cnt(8'h03, 1'b1, 8'h01);
		edge_cnt(8'h00, 1'b0, 8'h00);
		chk("trig_en", 8'h00, {7'h00, tpe});
		$display("test start done");
	endtask : t_start
	task automatic t_rerun;
		ext <= 8'h5a;
		reset_i <= 1'b1;
		tick(2);
		reset_i <= 1'b0;
		tick(1);
		t_reset();
	endtask : t_rerun
	initial begin
		tick(6);
		reset_i <= 1'b0;
		tick(1);
		t_reset();
		t_io();
		t_analog();
		t_fsel();
		t_start();
		t_rerun();
		wrap_up();
	end
endmodule : testbench
bind asio_port asio_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_sel_i(channel_sel_i),
	.scan_mode_i(scan_mode_i), .analog_sel_o(analog_sel_o));
